// *** updown_counter_pkg.sv ***
// package: constants, register map and carrier types for the up/down pulse counter
package updown_counter_pkg;
	localparam int NUM_CH = 4;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_RUN = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_CH_BASE = 12'h010;
	localparam logic [11:0] OFS_CH_STRIDE = 12'h010;
	localparam logic [3:0] SUB_UPPER = 4'h0;
	localparam logic [3:0] SUB_LOWER = 4'h4;
	localparam logic [3:0] SUB_START = 4'h8;
	localparam logic [3:0] SUB_VALUE = 4'hC;
	localparam int CTRL_EN = 0;
	localparam int CTRL_CLR = 1;
	localparam int CTRL_DIR = 2;
	localparam int CTRL_PRE = 3;
	localparam int CTRL_VIS = 4;
	localparam int CTRL_SEL = 5;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
	localparam logic [31:0] UPPER_RESET = 32'h7FFF_FFFF;
	localparam logic [31:0] LOWER_RESET = 32'h0000_0000;
	localparam logic [31:0] START_RESET = 32'h0000_0000;
	localparam logic [2:0] RETAIN_RESET = 3'h0;
	localparam logic [31:0] VALUE_MAX = 32'h7FFF_FFFF;
	localparam logic [31:0] VALUE_MIN = 32'h8000_0000;

	typedef struct packed {
		logic enable;
		logic clear;
		logic up;
		logic preload;
	} coils_s;

	typedef struct packed {
		logic upper;
		logic lower;
		logic zero;
		logic range;
	} contacts_s;
endpackage

// *** pin_sync.sv ***
// two-flop synchroniser with rising-edge pulse for one pulse input
module pin_sync
	import updown_counter_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pin and result
	input wire logic pin,
	output logic level,
	output logic rise
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise = sync_reg & ~last_reg;
endmodule

// *** counter_channel.sv ***
// one signed 32-bit up/down counter with threshold contacts
module counter_channel
	import updown_counter_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic retain,
	input wire logic count_pulse,
	input wire coils_s coils,
	input wire logic [31:0] upper_setpoint,
	input wire logic [31:0] lower_setpoint,
	input wire logic [31:0] start_value,
	// results
	output logic [31:0] actual_value,
	output contacts_s contacts
);
	logic [31:0] value_reg;
	logic [31:0] value_next;
	logic range_reg;
	logic range_next;
	logic preload_last_reg;
	logic run_last_reg;
	logic preload_rise;
	logic at_limit;

	assign preload_rise = coils.preload & ~preload_last_reg;
	assign at_limit = coils.up ? (value_reg == VALUE_MAX) : (value_reg == VALUE_MIN);

	always_comb begin
		value_next = value_reg;
		range_next = range_reg;
		if (run_last_reg && !run && !retain) begin
			value_next = '0;
			range_next = 1'b0;
		end else if (run && coils.clear) begin
			value_next = '0;
			range_next = 1'b0;
		end else if (run && preload_rise) begin
			value_next = start_value;
			range_next = 1'b0;
		end else if (run && coils.enable && count_pulse) begin
			if (at_limit) begin
				range_next = 1'b1;
			end else begin
				value_next = coils.up ? value_reg + 32'h0000_0001 : value_reg - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_reg <= '0;
			range_reg <= 1'b0;
			preload_last_reg <= 1'b0;
			run_last_reg <= 1'b0;
		end else begin
			value_reg <= value_next;
			range_reg <= range_next;
			preload_last_reg <= coils.preload;
			run_last_reg <= run;
		end
	end

	// contacts follow the held value; an excursion leaves the value pinned at a limit, so the
	// matching threshold contact stays closed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			contacts <= '0;
			actual_value <= '0;
		end else begin
			contacts.upper <= $signed(value_next) >= $signed(upper_setpoint);
			contacts.lower <= $signed(value_next) <= $signed(lower_setpoint);
			contacts.zero <= value_next == 32'h0000_0000;
			contacts.range <= range_next;
			actual_value <= value_next;
		end
	end
endmodule

// *** updown_pulse_counter.sv ***
// top: four up/down pulse counters behind an APB slave
// Operation
// - four counters, each counting pulses from the input chosen by its select field, in order
// - a counter counts only while its enable coil is set
// - clear coil sets the value to zero, zero contact then closes
// - direction coil set counts up, cleared counts down
// - preload rising edge loads start value, contacts follow
// - upper contact closed while value at or above upper setpoint
// - lower contact closed while value at or below lower setpoint
// - zero contact closed exactly while value equals zero
// - overflowing step closes range contact, value held at last valid
// - setpoints, start and actual value are signed 32-bit
// - value output always shows the current actual value
// - clear coil works only in run; non-retentive counters also clear on run-to-stop
// - retentive counters keep value over run-to-stop and power loss; here presetn clears every counter value to zero
// - started in run, a retentive counter resumes from its saved value
// - number of retentive counters is configurable, others do not retain
// - counting up from zero, zero and lower contacts release past lower
// - an excursion closes the threshold contact of its direction
// - inputs shared by counters: only the last in order counts
// - each counter has a visibility flag, shown by default
// - counting happens on rising input edges, independent of scan cycle
//
// Local design decisions: the APB slave port and the address map.
module updown_pulse_counter
	import updown_counter_pkg::*;
#(
	parameter int CHANNELS = NUM_CH
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// count pulse inputs
	input wire logic [CHANNELS-1:0] count_in,
	// contacts and values
	output logic [CHANNELS-1:0] upper_threshold_contact,
	output logic [CHANNELS-1:0] lower_threshold_contact,
	output logic [CHANNELS-1:0] zero_contact,
	output logic [CHANNELS-1:0] out_of_range_contact,
	output logic [CHANNELS*32-1:0] actual_value_out
);
	logic [31:0] ctrl_reg [CHANNELS];
	logic [31:0] upper_reg [CHANNELS];
	logic [31:0] lower_reg [CHANNELS];
	logic [31:0] start_reg [CHANNELS];
	logic run_reg;
	logic [2:0] retain_count_reg;
	logic [31:0] value_w [CHANNELS];
	contacts_s contacts_w [CHANNELS];
	logic [CHANNELS-1:0] level_w;
	logic [CHANNELS-1:0] rise_w;
	logic [CHANNELS-1:0] owner_w;
	logic access;
	logic wr;
	logic ch_hit;
	logic [1:0] ch_idx;
	logic [3:0] sub;
	logic [31:0] rd_next;
	logic err_next;

	function automatic logic [1:0] chan_of(input logic [11:0] a);
		logic [11:0] d;
		d = a - OFS_CH_BASE;
		return d[5:4];
	endfunction

	assign access = psel & penable & ~pready;
	assign wr = access & pwrite;
	assign ch_hit = (paddr >= OFS_CH_BASE) && (paddr < OFS_CH_BASE + OFS_CH_STRIDE * 12'(CHANNELS));
	assign ch_idx = chan_of(paddr);
	assign sub = paddr[3:0];

	// an instance counts its selected input only when no later instance selects the same
	// input, so a shared input is always won by the latest in order, whatever it is
	always_comb begin
		owner_w = '1;
		for (int i = 0; i < CHANNELS; i++) begin
			for (int j = i + 1; j < CHANNELS; j++) begin
				if (ctrl_reg[j][CTRL_SEL +: 2] == ctrl_reg[i][CTRL_SEL +: 2]) begin
					owner_w[i] = 1'b0;
				end
			end
		end
	end

	generate
		for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
			coils_s coils;
			logic retentive;
			logic pulse;
			logic [1:0] src;
			assign src = ctrl_reg[g][CTRL_SEL +: 2];
			assign pulse = rise_w[src] & owner_w[g];
			// one assignment for the whole struct keeps a single driver on the variable
			assign coils = {ctrl_reg[g][CTRL_EN], ctrl_reg[g][CTRL_CLR], ctrl_reg[g][CTRL_DIR],
				ctrl_reg[g][CTRL_PRE]};
			assign retentive = 3'(g) < retain_count_reg;

			pin_sync u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.pin(count_in[g]),
				.level(level_w[g]),
				.rise(rise_w[g])
			);

			counter_channel u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.run(run_reg),
				.retain(retentive),
				.count_pulse(pulse),
				.coils(coils),
				.upper_setpoint(upper_reg[g]),
				.lower_setpoint(lower_reg[g]),
				.start_value(start_reg[g]),
				.actual_value(value_w[g]),
				.contacts(contacts_w[g])
			);
		end
	endgenerate

	// one process for all output bits: split processes on one vector would give it several drivers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_threshold_contact <= '0;
			lower_threshold_contact <= '0;
			zero_contact <= '0;
			out_of_range_contact <= '0;
			actual_value_out <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				upper_threshold_contact[i] <= contacts_w[i].upper;
				lower_threshold_contact[i] <= contacts_w[i].lower;
				zero_contact[i] <= contacts_w[i].zero;
				out_of_range_contact[i] <= contacts_w[i].range;
				actual_value_out[i*32 +: 32] <= value_w[i];
			end
		end
	end

	// register writes; setpoints and start are full 32-bit signed words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < CHANNELS; i++) begin
				ctrl_reg[i] <= CTRL_RESET;
				upper_reg[i] <= UPPER_RESET;
				lower_reg[i] <= LOWER_RESET;
				start_reg[i] <= START_RESET;
			end
			run_reg <= 1'b0;
			retain_count_reg <= RETAIN_RESET;
		end else if (wr) begin
			if (paddr == OFS_RUN) begin
				run_reg <= pwdata[0];
			end else if (paddr == OFS_CTRL) begin
				retain_count_reg <= pwdata[2:0];
			end else if (ch_hit) begin
				unique case (sub)
					SUB_UPPER: upper_reg[ch_idx] <= pwdata;
					SUB_LOWER: lower_reg[ch_idx] <= pwdata;
					SUB_START: start_reg[ch_idx] <= pwdata;
					SUB_VALUE: ctrl_reg[ch_idx] <= {25'h0, pwdata[6:0]};
					default: ctrl_reg[ch_idx] <= ctrl_reg[ch_idx];
				endcase
			end
		end
	end

	always_comb begin
		rd_next = '0;
		err_next = 1'b0;
		if (paddr == OFS_CTRL) begin
			rd_next = {29'h0, retain_count_reg};
		end else if (paddr == OFS_RUN) begin
			rd_next = {31'h0, run_reg};
		end else if (paddr == OFS_STATUS) begin
			for (int i = 0; i < CHANNELS; i++) begin
				rd_next[i*4 +: 4] = contacts_w[i];
			end
			rd_next[16 +: CHANNELS] = level_w;
		end else if (ch_hit) begin
			unique case (sub)
				SUB_UPPER: rd_next = upper_reg[ch_idx];
				SUB_LOWER: rd_next = lower_reg[ch_idx];
				SUB_START: rd_next = start_reg[ch_idx];
				SUB_VALUE: rd_next = ctrl_reg[ch_idx];
				default: err_next = 1'b1;
			endcase
		end else begin
			err_next = 1'b1;
		end
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= access;
			pslverr <= access & err_next;
			prdata <= (access & ~pwrite) ? rd_next : 32'h0000_0000;
		end
	end

	// outputs trail the counters by two registers; right after release their reset values
	// disagree with the value, so value checks wait until that pipeline has filled
	logic [1:0] settle_reg;
	logic settled;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_reg <= 2'h0;
		end else if (!settled) begin
			settle_reg <= settle_reg + 2'h1;
		end
	end

	assign settled = &settle_reg;

	property p_zero_after_clear;
		@(posedge pclk) disable iff (!presetn)
		(run_reg && ctrl_reg[0][CTRL_CLR]) |=> ##1 zero_contact[0];
	endproperty
	a_zero_after_clear: assert property (p_zero_after_clear) else $error("zero contact missing after clear");

	property p_upper;
		@(posedge pclk) disable iff (!presetn)
		settled |-> upper_threshold_contact[0] == ($signed(actual_value_out[31:0]) >= $signed($past(upper_reg[0], 2)));
	endproperty
	a_upper: assert property (p_upper) else $error("upper contact mismatch");

	property p_lower;
		@(posedge pclk) disable iff (!presetn)
		settled |-> lower_threshold_contact[0] == ($signed(actual_value_out[31:0]) <= $signed($past(lower_reg[0], 2)));
	endproperty
	a_lower: assert property (p_lower) else $error("lower contact mismatch");

	property p_zero;
		@(posedge pclk) disable iff (!presetn)
		settled |-> zero_contact[1] == (actual_value_out[63:32] == 32'h0000_0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero contact mismatch");

	property p_step_one;
		@(posedge pclk) disable iff (!presetn)
		(run_reg && !ctrl_reg[0][CTRL_CLR] && !ctrl_reg[0][CTRL_PRE] && $past(run_reg))
		|-> (actual_value_out[31:0] - $past(actual_value_out[31:0]) == 32'h0000_0001)
		|| (actual_value_out[31:0] == $past(actual_value_out[31:0]))
		|| ($past(actual_value_out[31:0]) - actual_value_out[31:0] == 32'h0000_0001);
	endproperty
	a_step_one: assert property (p_step_one) else $error("count step not one");

	property p_hold_on_range;
		@(posedge pclk) disable iff (!presetn)
		$rose(out_of_range_contact[2]) |-> $stable(actual_value_out[95:64]);
	endproperty
	a_hold_on_range: assert property (p_hold_on_range) else $error("value moved on overflow");

	property p_no_count_disabled;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl_reg[3][CTRL_EN] && !ctrl_reg[3][CTRL_CLR] && !ctrl_reg[3][CTRL_PRE] && run_reg) [*3]
		|-> $stable(actual_value_out[127:96]);
	endproperty
	a_no_count_disabled: assert property (p_no_count_disabled) else $error("counted while disabled");

	property p_stop_no_clear;
		@(posedge pclk) disable iff (!presetn)
		(!run_reg && $past(!run_reg) && $past(!run_reg, 2) && $past(!run_reg, 3)) |-> $stable(actual_value_out[31:0]);
	endproperty
	a_stop_no_clear: assert property (p_stop_no_clear) else $error("value changed in stop");

	property p_retain_stop;
		@(posedge pclk) disable iff (!presetn)
		($fell(run_reg) && retain_count_reg != 3'h0) |-> ##2 $stable(actual_value_out[31:0]);
	endproperty
	a_retain_stop: assert property (p_retain_stop) else $error("retentive value lost on stop");

	// clear beats preload, so a preload edge under clear is left out
	property p_preload_load;
		@(posedge pclk) disable iff (!presetn)
		(run_reg && ctrl_reg[2][CTRL_PRE] && !$past(ctrl_reg[2][CTRL_PRE]) && !ctrl_reg[2][CTRL_CLR])
		|-> ##2 (actual_value_out[95:64] == $past(start_reg[2], 2));
	endproperty
	a_preload_load: assert property (p_preload_load) else $error("start value not loaded");

	property p_range_dir;
		@(posedge pclk) disable iff (!presetn)
		$rose(out_of_range_contact[1])
		|-> ((actual_value_out[63:32] == VALUE_MIN) && lower_threshold_contact[1])
		|| ((actual_value_out[63:32] == VALUE_MAX) && upper_threshold_contact[1]);
	endproperty
	a_range_dir: assert property (p_range_dir) else $error("excursion contact wrong");

	property p_ready_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("apb ready held too long");

	property p_apb_ready;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) ##1 (psel && penable) |-> ##1 pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");

	c_overflow: cover property (@(posedge pclk) disable iff (!presetn) $rose(out_of_range_contact[2]));
	c_preload: cover property (@(posedge pclk) disable iff (!presetn) run_reg && $rose(ctrl_reg[2][CTRL_PRE]));
	c_retain: cover property (@(posedge pclk) disable iff (!presetn) $fell(run_reg) && retain_count_reg != 3'h0);
	c_upper: cover property (@(posedge pclk) disable iff (!presetn) $rose(upper_threshold_contact[0]));
	c_zero_leave: cover property (@(posedge pclk) disable iff (!presetn) $fell(zero_contact[0]));
endmodule

// *** pulse_source.sv ***
// pulse source model: square-wave count pulses on the four counter input pins
module pulse_source #(
	parameter int HALF = 4
)
(
	// clock
	input wire logic pclk,
	// count pins, idle low
	output logic [3:0] pins
);
	timeunit 1ns;
	timeprecision 100ps;

	initial pins = 4'h0;

	// equal mark and space; the frequency band is scaled down so runs stay short
	task automatic send(input int ch, input int n);
		repeat (n) begin
			@(posedge pclk);
			pins[ch] <= 1'b1;
			repeat (HALF) @(posedge pclk);
			pins[ch] <= 1'b0;
			repeat (HALF - 1) @(posedge pclk);
		end
		// let the synchroniser and counter settle before anyone looks
		repeat (8) @(posedge pclk);
	endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the four-channel up/down pulse counter
module tb_top;
	import updown_counter_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] count_in, up_c, lo_c, ze_c, rg_c;
	logic [127:0] vals;
	int fail_count = 0;
	int total_checks = 0;

	updown_pulse_counter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_in(count_in),
		.upper_threshold_contact(up_c), .lower_threshold_contact(lo_c), .zero_contact(ze_c),
		.out_of_range_contact(rg_c), .actual_value_out(vals));
	pulse_source src_u (.pclk(pclk), .pins(count_in));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic summarize();
		if (fail_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			summarize();
		end
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdck(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check32(rd, exp);
	endtask

	function automatic logic [11:0] ca(input int i, input logic [3:0] s);
		return OFS_CH_BASE + 12'(OFS_CH_STRIDE * i) + {8'h00, s};
	endfunction

	// coil word with visibility kept shown
	function automatic logic [31:0] cw(input logic en, input logic clr, input logic up, input logic pre,
		input logic [1:0] sel);
		return {25'h0, sel, 1'b1, pre, up, clr, en};
	endfunction

	// contacts c = {upper, lower, zero, range}
	task automatic chk(input int i, input logic [31:0] v, input logic [3:0] c);
		// no completion flag for the counter itself, so give a register write time to reach it
		repeat (4) @(posedge pclk);
		check32(vals[32*i +: 32], v);
		check32({28'h0, up_c[i], lo_c[i], ze_c[i], rg_c[i]}, {28'h0, c});
	endtask

	task automatic pl(input int i, input logic [31:0] sv, input logic [31:0] coil);
		wr(ca(i, SUB_START), sv);
		wr(ca(i, SUB_VALUE), coil | 32'h8);
		wr(ca(i, SUB_VALUE), coil);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < NUM_CH; i++) begin
			rdck(ca(i, SUB_UPPER), UPPER_RESET);
			rdck(ca(i, SUB_LOWER), LOWER_RESET);
			rdck(ca(i, SUB_START), START_RESET);
			rdck(ca(i, SUB_VALUE), CTRL_RESET);
			chk(i, 32'h0, 4'h6);
		end
		rdck(OFS_CTRL, {29'h0, RETAIN_RESET});
		rdck(OFS_RUN, 32'h0);
		apb(1'b0, 12'hFF0, 32'h0);
		check1(rerr, 1'b1);
		wr(OFS_RUN, 32'h1);
		for (int i = 0; i < NUM_CH; i++) begin
			wr(ca(i, SUB_VALUE), cw(1'b1, 1'b0, i != 1, 1'b0, 2'(i)));
		end
		wr(ca(0, SUB_UPPER), 32'h3);
		src_u.send(0, 3);
		chk(0, 32'h3, 4'h8);
		chk(2, 32'h0, 4'h6);
		src_u.send(1, 2);
		chk(1, 32'hFFFF_FFFE, 4'h4);
		wr(ca(0, SUB_VALUE), cw(1'b1, 1'b1, 1'b1, 1'b0, 2'd0));
		wr(ca(0, SUB_VALUE), cw(1'b1, 1'b0, 1'b1, 1'b0, 2'd0));
		chk(0, 32'h0, 4'h6);
		wr(OFS_CTRL, 32'h1);
		src_u.send(0, 2);
		chk(0, 32'h2, 4'h0);
		wr(OFS_RUN, 32'h0);
		chk(0, 32'h2, 4'h0);
		chk(1, 32'h0, 4'h6);
		src_u.send(0, 1);
		chk(0, 32'h2, 4'h0);
		wr(ca(0, SUB_VALUE), cw(1'b1, 1'b1, 1'b1, 1'b0, 2'd0));
		wr(ca(0, SUB_VALUE), cw(1'b1, 1'b0, 1'b1, 1'b0, 2'd0));
		chk(0, 32'h2, 4'h0);
		wr(OFS_RUN, 32'h1);
		src_u.send(0, 1);
		chk(0, 32'h3, 4'h8);
		pl(2, 32'h7FFF_FFFE, cw(1'b1, 1'b0, 1'b1, 1'b0, 2'd2));
		chk(2, 32'h7FFF_FFFE, 4'h0);
		src_u.send(2, 1);
		chk(2, 32'h7FFF_FFFF, 4'h8);
		src_u.send(2, 1);
		chk(2, 32'h7FFF_FFFF, 4'h9);
		apb(1'b0, OFS_STATUS, 32'h0);
		check32({28'h0, rd[11:8]}, 32'h9);
		pl(1, 32'h8000_0000, cw(1'b1, 1'b0, 1'b0, 1'b0, 2'd1));
		chk(1, 32'h8000_0000, 4'h4);
		src_u.send(1, 1);
		chk(1, 32'h8000_0000, 4'h5);
		wr(ca(3, SUB_VALUE), cw(1'b0, 1'b0, 1'b1, 1'b0, 2'd3));
		src_u.send(3, 2);
		chk(3, 32'h0, 4'h6);
		wr(ca(3, SUB_VALUE), cw(1'b1, 1'b0, 1'b1, 1'b0, 2'd0));
		src_u.send(0, 1);
		chk(3, 32'h1, 4'h0);
		chk(0, 32'h3, 4'h8);
		summarize();
	end
endmodule
